// ===== verilog/ppr_matrix.sv
// Purpose: Routes peripheral outputs onto remap pins and pins onto peripheral inputs.
// Assumes: All inputs synchronous to ref_clk; writes qualified by key and lock.
// Notes: Pad outputs and mapped inputs are registered, one cycle of latency.
`timescale 1ns/1ps

// Functional notes
// R1: Remappable peripheral reaches pin only when selected
// R2: Fixed peripherals stay on their default pin
// R3: Remapped output overrides other digital pin functions
// R4: Analog use of pin always beats remap
// R5: Separate selector sets for inputs and outputs
// R6: Each remap pin owns one output selector
// R7: Six-bit selectors, two per 16-bit word
// R8: Selectors reset to null, default port
// R9: Input-only pins never driven by remap
// R10: No lockout between selectors, any combination
// R11: Fan-out and fan-in of peripherals allowed
// R12: Key and lock guard selector changes
// R13: Codes 1 and 3 select UART transmits
// R14: Codes 8, 9, 10 select SPI B outputs
// R15: Code 14 selects CAN transmit when present
// R16: Codes 16 to 19 select compare outputs
// R17: Codes 24-26 and 50 select comparators
// R18: Codes 45, 47, 49 select sync, quad, refclk
// R19: Two-wire, PWM, analog modules stay fixed pins
// R20: Unassigned code behaves as null selection
module ppr_matrix #(
  parameter bit HAS_CAN = 1'b1,
  parameter bit HAS_MOTOR = 1'b1
) (
  input wire logic ref_clk, // System clock, 40 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic cfg_lock, // High blocks selector writes
  input wire logic [ppr_pkg::KEY_W-1:0] wr_key, // Must match for a write
  input wire logic out_wr, // Output selector write strobe
  input wire logic [2:0] out_wr_pin, // Remap pin to write
  input wire ppr_pkg::ppr_sel_t out_wr_sel, // New output selector
  input wire logic in_wr, // Input selector write strobe
  input wire logic [2:0] in_wr_chan, // Peripheral input to write
  input wire ppr_pkg::ppr_sel_t in_wr_sel, // New input selector
  input wire logic [1:0] route_rd_idx, // Output route word to read
  input wire ppr_pkg::ppr_periph_out_t periph_out, // Peripheral output levels
  input wire logic [ppr_pkg::NUM_IO-1:0] port_out, // Default port data
  input wire logic [ppr_pkg::NUM_IO-1:0] port_oe_n, // Default port enable, low drives
  input wire logic [ppr_pkg::NUM_IO-1:0] fixed_out, // Fixed peripheral data
  input wire logic [ppr_pkg::NUM_IO-1:0] fixed_act, // Fixed peripheral owns pin
  input wire logic [ppr_pkg::NUM_IO-1:0] analog_en, // Pin in analog use
  input wire logic [ppr_pkg::NUM_PINS-1:0] pad_in, // Pad input levels
  output ppr_pkg::ppr_periph_in_t periph_in_r, // Mapped peripheral inputs
  output logic [ppr_pkg::NUM_IO-1:0] pad_out_r, // Pad output data
  output logic [ppr_pkg::NUM_IO-1:0] pad_oe_n_r, // Pad enable, low drives
  output logic [ppr_pkg::ROUTE_W-1:0] route_rd_data_r, // Output route word
  output logic wr_reject_r // Pulse: write refused
);

  ppr_pkg::ppr_sel_t out_sel_r [ppr_pkg::NUM_IO];
  ppr_pkg::ppr_sel_t in_sel_r [ppr_pkg::NUM_PIN_IN];
  logic wr_ok;
  logic [ppr_pkg::NUM_IO-1:0] hit;
  logic [ppr_pkg::NUM_IO-1:0] val;
  logic [ppr_pkg::NUM_PIN_IN-1:0] in_pick;
  logic [ppr_pkg::NUM_PIN_IN-1:0] periph_in_vec;

  // Returns {selected, level}; a miss leaves the pin to lower priorities
  function automatic logic [1:0] route_pick(input ppr_pkg::ppr_sel_t sel,
                                            input ppr_pkg::ppr_periph_out_t p);
    logic [1:0] r;
    r = 2'h0;
    case (sel)
      ppr_pkg::SEL_UART_A_TX: r = {1'b1, p.uart_a_transmit}; // R13
      ppr_pkg::SEL_UART_B_TX: r = {1'b1, p.uart_b_transmit}; // R13
      ppr_pkg::SEL_SPI_B_DO: r = {1'b1, p.spi_b_data_out}; // R14
      ppr_pkg::SEL_SPI_B_CK: r = {1'b1, p.spi_b_clock_out}; // R14
      ppr_pkg::SEL_SPI_B_SS: r = {1'b1, p.spi_b_select_out}; // R14
      ppr_pkg::SEL_CAN_TX: r = {HAS_CAN, p.can_transmit & HAS_CAN}; // R15
      ppr_pkg::SEL_CMP_OUT_1: r = {1'b1, p.compare_out[0]}; // R16
      ppr_pkg::SEL_CMP_OUT_2: r = {1'b1, p.compare_out[1]}; // R16
      ppr_pkg::SEL_CMP_OUT_3: r = {1'b1, p.compare_out[2]}; // R16
      ppr_pkg::SEL_CMP_OUT_4: r = {1'b1, p.compare_out[3]}; // R16
      ppr_pkg::SEL_CMPR_1: r = {1'b1, p.comparator_out[0]}; // R17
      ppr_pkg::SEL_CMPR_2: r = {1'b1, p.comparator_out[1]}; // R17
      ppr_pkg::SEL_CMPR_3: r = {1'b1, p.comparator_out[2]}; // R17
      ppr_pkg::SEL_CMPR_4: r = {1'b1, p.comparator_out[3]}; // R17
      ppr_pkg::SEL_PWM_SYNC: begin
        r = {HAS_MOTOR, p.pwm_timebase_sync_out & HAS_MOTOR}; // R18
      end
      ppr_pkg::SEL_QUAD_CMP: begin
        r = {HAS_MOTOR, p.quad_counter_compare_out & HAS_MOTOR}; // R18
      end
      ppr_pkg::SEL_REF_CLK: r = {1'b1, p.reference_clock_out}; // R18
      // Null and every unassigned code fall back to the fixed peripheral or the port
      default: r = 2'h0; // R20 R8
    endcase
    return r;
  endfunction

  // Key plus lock: a stray store with the wrong key cannot remap a pin
  assign wr_ok = !cfg_lock && (wr_key == ppr_pkg::WR_KEY); // R12

  // Each pin has its own field and every value is accepted as written
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < ppr_pkg::NUM_IO; i++) begin
        out_sel_r[i] <= ppr_pkg::SEL_RESET; // R8
      end
    end else if (out_wr && wr_ok) begin
      out_sel_r[out_wr_pin] <= out_wr_sel; // R6 R10 R12
    end
  end

  // Input selectors are a separate set, indexed by peripheral input
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < ppr_pkg::NUM_PIN_IN; c++) begin
        in_sel_r[c] <= ppr_pkg::IN_SEL_NONE;
      end
    end else if (in_wr && wr_ok && (in_wr_chan < 3'(ppr_pkg::NUM_PIN_IN))) begin
      in_sel_r[in_wr_chan] <= in_wr_sel; // R5 R10
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reject_r <= 1'b0;
    end else begin
      wr_reject_r <= (out_wr || in_wr) && !wr_ok; // R12
    end
  end

  // Several pins may name one peripheral; no arbitration between them
  for (genvar i = 0; i < ppr_pkg::NUM_IO; i++) begin : g_pick
    assign {hit[i], val[i]} = route_pick(out_sel_r[i], periph_out); // R11
  end

  // Priority: analog, then remap, then fixed peripheral, then port.
  // Two-wire, PWM and analog modules only ever arrive as fixed_* signals.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_out_r <= '0;
      pad_oe_n_r <= '1;
    end else begin
      for (int i = 0; i < ppr_pkg::NUM_IO; i++) begin
        if (analog_en[i]) begin
          pad_out_r[i] <= 1'b0; // R4
          pad_oe_n_r[i] <= 1'b1; // R4
        end else if (hit[i]) begin
          pad_out_r[i] <= val[i]; // R3 R1
          pad_oe_n_r[i] <= 1'b0; // R3
        end else if (fixed_act[i]) begin
          pad_out_r[i] <= fixed_out[i]; // R2 R19
          pad_oe_n_r[i] <= 1'b0; // R2
        end else begin
          pad_out_r[i] <= port_out[i]; // R8 R1
          pad_oe_n_r[i] <= port_oe_n[i];
        end
      end
    end
  end

  // Input-only pins sit above the two-way ones and are reachable only here
  for (genvar c = 0; c < ppr_pkg::NUM_PIN_IN; c++) begin : g_in
    assign in_pick[c] = (in_sel_r[c] != ppr_pkg::IN_SEL_NONE) &&
                        (in_sel_r[c] <= ppr_pkg::IN_SEL_MAX) &&
                        pad_in[4'(in_sel_r[c] - ppr_pkg::IN_SEL_STEP)]; // R9 R11
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      periph_in_r <= '0;
    end else begin
      periph_in_r <= ppr_pkg::ppr_periph_in_t'(in_pick); // R5
    end
  end

  // Two selectors per word, upper two bits of each byte read zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      route_rd_data_r <= '0;
    end else begin
      route_rd_data_r <= '0;
      route_rd_data_r[ppr_pkg::LO_FIELD_LSB +: ppr_pkg::SEL_W] <=
        out_sel_r[{route_rd_idx, 1'b0}]; // R7
      route_rd_data_r[ppr_pkg::HI_FIELD_LSB +: ppr_pkg::SEL_W] <=
        out_sel_r[{route_rd_idx, 1'b1}]; // R7
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_key_out_write;
    out_wr && !cfg_lock && (wr_key == ppr_pkg::WR_KEY);
  endsequence

  sequence s_guarded_write;
    (out_wr || in_wr) && (cfg_lock || (wr_key != ppr_pkg::WR_KEY));
  endsequence

  property p_write_lands;
    s_key_out_write |=> (out_sel_r[$past(out_wr_pin)] == $past(out_wr_sel));
  endproperty

  property p_guard_holds;
    s_guarded_write |=> (wr_reject_r && $stable(out_sel_r[0]) && $stable(in_sel_r[0]));
  endproperty

  chk_write_lands: assert property (p_write_lands) // R10
    else $error("unlocked output selector write lost");

  chk_guard_holds: assert property (p_guard_holds) // R12
    else $error("guarded write changed a selector");

  for (genvar i = 0; i < ppr_pkg::NUM_IO; i++) begin : g_chk
    chk_analog_wins: assert property (analog_en[i] |=> pad_oe_n_r[i]) // R4
      else $error("analog pin driven digitally");

    chk_remap_wins: assert property ( // R3
      (!analog_en[i] && hit[i]) |=> (!pad_oe_n_r[i] && pad_out_r[i] == $past(val[i])))
      else $error("remapped output did not own pin");

    chk_null_port: assert property ( // R20
      (!analog_en[i] && !hit[i] && !fixed_act[i]) |=>
        (pad_out_r[i] == $past(port_out[i]) && pad_oe_n_r[i] == $past(port_oe_n[i])))
      else $error("null selection did not leave port control");

    chk_fixed_pin: assert property ( // R2
      (!analog_en[i] && !hit[i] && fixed_act[i]) |=>
        (!pad_oe_n_r[i] && pad_out_r[i] == $past(fixed_out[i])))
      else $error("fixed peripheral missing from its pin");
  end

  chk_uart_code: assert property ( // R13
    (out_sel_r[0] == ppr_pkg::SEL_UART_B_TX && !analog_en[0]) |=>
      (pad_out_r[0] == $past(periph_out.uart_b_transmit) && !pad_oe_n_r[0]))
    else $error("uart b code not routed");

  chk_compare_code: assert property ( // R16
    (out_sel_r[0] == ppr_pkg::SEL_CMP_OUT_4 && !analog_en[0]) |=>
      (pad_out_r[0] == $past(periph_out.compare_out[3])))
    else $error("compare 4 code not routed");

  chk_comparator_code: assert property ( // R17
    (out_sel_r[0] == ppr_pkg::SEL_CMPR_4 && !analog_en[0]) |=>
      (pad_out_r[0] == $past(periph_out.comparator_out[3])))
    else $error("comparator 4 code not routed");

  chk_input_route: assert property ( // R9
    (in_sel_r[0] == ppr_pkg::IN_SEL_MAX) |=>
      (periph_in_r.can_receive == $past(pad_in[ppr_pkg::NUM_PINS-1])))
    else $error("input-only pin not routed to input");

  chk_route_word: assert property ( // R7
    (route_rd_idx == 2'h0) |=>
      (route_rd_data_r[ppr_pkg::HI_FIELD_LSB +: ppr_pkg::SEL_W] == $past(out_sel_r[1])))
    else $error("route word upper field wrong");

  // Flat view of the mapped inputs, one bit per peripheral input
  assign periph_in_vec = periph_in_r;

  sequence s_key_in_write;
    in_wr && !cfg_lock && (wr_key == ppr_pkg::WR_KEY) &&
      (in_wr_chan < 3'(ppr_pkg::NUM_PIN_IN));
  endsequence

  property p_in_write_lands;
    s_key_in_write |=> (in_sel_r[$past(in_wr_chan)] == $past(in_wr_sel));
  endproperty

  property p_reject_cause;
    wr_reject_r |-> ($past(out_wr || in_wr) &&
      $past(cfg_lock || (wr_key != ppr_pkg::WR_KEY)));
  endproperty

  chk_in_write_lands: assert property (p_in_write_lands) // R5
    else $error("unlocked input selector write lost");

  chk_reject_cause: assert property (p_reject_cause) // R12
    else $error("refusal flagged without a guarded write");

  chk_accept_quiet: assert property (s_key_out_write |=> !wr_reject_r) // R10
    else $error("accepted write flagged as refused");

  // Reset must win even before the first write, so this one is never disabled
  chk_reset_null: assert property (disable iff (1'b0) // R8
    !rst_n |=> (pad_oe_n_r == '1 && pad_out_r == '0 && route_rd_data_r == '0 &&
      periph_in_r == '0 && !wr_reject_r))
    else $error("outputs not at their reset values");

  chk_route_low: assert property ( // R7
    1'b1 |=> (route_rd_data_r[ppr_pkg::LO_FIELD_LSB +: ppr_pkg::SEL_W] ==
      $past(out_sel_r[{route_rd_idx, 1'b0}])))
    else $error("route word lower field wrong");

  for (genvar i = 0; i < ppr_pkg::NUM_IO; i++) begin : g_hold
    chk_field_owned: assert property ( // R6
      !(out_wr && wr_ok && (out_wr_pin == 3'(i))) |=> $stable(out_sel_r[i]))
      else $error("output selector changed without its own write");
  end

  for (genvar c = 0; c < ppr_pkg::NUM_PIN_IN; c++) begin : g_in_chk
    chk_in_owned: assert property ( // R5
      !(in_wr && wr_ok && (in_wr_chan == 3'(c))) |=> $stable(in_sel_r[c]))
      else $error("input selector changed without its own write");

    chk_in_null: assert property ( // R5
      ((in_sel_r[c] == ppr_pkg::IN_SEL_NONE) || (in_sel_r[c] > ppr_pkg::IN_SEL_MAX)) |=>
        !periph_in_vec[c])
      else $error("unconnected peripheral input not held low");
  end

  chk_uart_a_code: assert property ( // R13
    (out_sel_r[0] == ppr_pkg::SEL_UART_A_TX && !analog_en[0]) |=>
      (pad_out_r[0] == $past(periph_out.uart_a_transmit) && !pad_oe_n_r[0]))
    else $error("uart a code not routed");

  chk_spi_code: assert property ( // R14
    (out_sel_r[0] == ppr_pkg::SEL_SPI_B_CK && !analog_en[0]) |=>
      (pad_out_r[0] == $past(periph_out.spi_b_clock_out) && !pad_oe_n_r[0]))
    else $error("spi b clock code not routed");

  chk_select_code: assert property ( // R14
    (out_sel_r[0] == ppr_pkg::SEL_SPI_B_SS && !analog_en[0]) |=>
      (pad_out_r[0] == $past(periph_out.spi_b_select_out) && !pad_oe_n_r[0]))
    else $error("spi b select code not routed");

  chk_refclk_code: assert property ( // R18
    (out_sel_r[0] == ppr_pkg::SEL_REF_CLK && !analog_en[0]) |=>
      (pad_out_r[0] == $past(periph_out.reference_clock_out) && !pad_oe_n_r[0]))
    else $error("reference clock code not routed");

  // Variants without the CAN or motor blocks must treat their codes as null
  chk_can_present: assert property ( // R15
    (HAS_CAN && out_sel_r[0] == ppr_pkg::SEL_CAN_TX && !analog_en[0]) |=>
      (pad_out_r[0] == $past(periph_out.can_transmit) && !pad_oe_n_r[0]))
    else $error("can code not routed");

  chk_can_absent: assert property ( // R15
    (!HAS_CAN && out_sel_r[0] == ppr_pkg::SEL_CAN_TX && !analog_en[0] && !fixed_act[0]) |=>
      (pad_out_r[0] == $past(port_out[0]) && pad_oe_n_r[0] == $past(port_oe_n[0])))
    else $error("absent can code took the pin");

  chk_motor_absent: assert property ( // R18
    (!HAS_MOTOR && !analog_en[0] && !fixed_act[0] &&
      (out_sel_r[0] == ppr_pkg::SEL_PWM_SYNC || out_sel_r[0] == ppr_pkg::SEL_QUAD_CMP)) |=>
      (pad_out_r[0] == $past(port_out[0]) && pad_oe_n_r[0] == $past(port_oe_n[0])))
    else $error("absent motor code took the pin");

endmodule

// ===== verilog/ppr_pkg.sv
// Purpose: Shared constants and carriers for the peripheral pin remap matrix.
// Assumes: Selector widths and pin counts are fixed for this derivative.
// Notes: Pin index 0..7 are two-way remap pins, 8..11 are input-only pins.
package ppr_pkg;
  localparam int SEL_W = 6;
  localparam int NUM_IO = 8;
  localparam int NUM_IN_ONLY = 4;
  localparam int NUM_PINS = NUM_IO + NUM_IN_ONLY;
  localparam int NUM_PIN_IN = 6;
  localparam int ROUTE_W = 16;
  localparam int ROUTE_REGS = NUM_IO / 2;
  localparam int KEY_W = 8;

  typedef logic [SEL_W-1:0] ppr_sel_t;

  // Output selector codes
  localparam ppr_sel_t SEL_NULL = 6'h00;
  localparam ppr_sel_t SEL_UART_A_TX = 6'h01;
  localparam ppr_sel_t SEL_UART_B_TX = 6'h03;
  localparam ppr_sel_t SEL_SPI_B_DO = 6'h08;
  localparam ppr_sel_t SEL_SPI_B_CK = 6'h09;
  localparam ppr_sel_t SEL_SPI_B_SS = 6'h0a;
  localparam ppr_sel_t SEL_CAN_TX = 6'h0e;
  localparam ppr_sel_t SEL_CMP_OUT_1 = 6'h10;
  localparam ppr_sel_t SEL_CMP_OUT_2 = 6'h11;
  localparam ppr_sel_t SEL_CMP_OUT_3 = 6'h12;
  localparam ppr_sel_t SEL_CMP_OUT_4 = 6'h13;
  localparam ppr_sel_t SEL_CMPR_1 = 6'h18;
  localparam ppr_sel_t SEL_CMPR_2 = 6'h19;
  localparam ppr_sel_t SEL_CMPR_3 = 6'h1a;
  localparam ppr_sel_t SEL_PWM_SYNC = 6'h2d;
  localparam ppr_sel_t SEL_QUAD_CMP = 6'h2f;
  localparam ppr_sel_t SEL_REF_CLK = 6'h31;
  localparam ppr_sel_t SEL_CMPR_4 = 6'h32;
  localparam ppr_sel_t SEL_RESET = SEL_NULL;

  // Input selector: 0 is unconnected, code k picks pin k-1
  localparam ppr_sel_t IN_SEL_NONE = 6'h00;
  localparam ppr_sel_t IN_SEL_MAX = 6'h0c;
  localparam ppr_sel_t IN_SEL_STEP = 6'h01;

  // Field placement inside a 16-bit output route word
  localparam int LO_FIELD_LSB = 0;
  localparam int HI_FIELD_LSB = 8;

  localparam logic [KEY_W-1:0] WR_KEY = 8'h5a;

  typedef struct packed {
    logic uart_a_transmit;
    logic uart_b_transmit;
    logic spi_b_data_out;
    logic spi_b_clock_out;
    logic spi_b_select_out;
    logic can_transmit;
    logic [3:0] compare_out;
    logic [3:0] comparator_out;
    logic pwm_timebase_sync_out;
    logic quad_counter_compare_out;
    logic reference_clock_out;
  } ppr_periph_out_t;

  typedef struct packed {
    logic uart_a_receive;
    logic uart_b_receive;
    logic spi_b_data_in;
    logic spi_b_clock_in;
    logic spi_b_select_in;
    logic can_receive;
  } ppr_periph_in_t;
endpackage

// ===== tb/ppr_pad_model.sv
// Purpose: Pad ring model that returns pin levels to the remap matrix.
// Assumes: Two-way pins 0..7 are driven by the matrix; pins 8..11 only by the bench.
// Notes: A released pin toggles every cycle so a stale level cannot pass for a real one.
`timescale 1ns/1ps
module ppr_pad_model (
  input wire logic ref_clk, // Pad sampling clock
  input wire logic [7:0] pad_out_r, // Pad data from the matrix
  input wire logic [7:0] pad_oe_n_r, // Pad enable, low drives
  input wire logic [3:0] ext_in, // Levels on input-only pins
  output logic [11:0] pad_in // Levels seen back at the pads
);
  logic [7:0] last_r = 8'h00;

  always @(posedge ref_clk) begin
    last_r <= pad_in[7:0];
  end

  // Input-only pins have no output path at all
  assign pad_in = {ext_in, (pad_out_r & ~pad_oe_n_r) | (~last_r & pad_oe_n_r)};
endmodule

// ===== tb/peripheral_pin_remap_matrix_tb.sv
// Purpose: Self-checking bench for the peripheral pin remap matrix.
// Assumes: Selector writes are one-cycle strobes with the write key.
// Notes: Pads and mapped inputs are checked one edge after their cause.
`timescale 1ns/1ps
module peripheral_pin_remap_matrix_tb;
  logic ref_clk = 1'b0, rst_n = 1'b0, cfg_lock = 1'b0, out_wr = 1'b0, in_wr = 1'b0;
  logic [7:0] wr_key = 8'h00;
  logic [2:0] out_wr_pin = 3'h0, in_wr_chan = 3'h0;
  ppr_pkg::ppr_sel_t out_wr_sel = 6'h00, in_wr_sel = 6'h00;
  logic [1:0] route_rd_idx = 2'h0;
  ppr_pkg::ppr_periph_out_t periph_out = '0;
  logic [7:0] port_out = 8'hff, port_oe_n = 8'h00, fixed_out = 8'h00;
  logic [7:0] fixed_act = 8'h00, analog_en = 8'h00, pad_out_r, pad_oe_n_r;
  logic [7:0] lite_out, lite_oe_n;
  logic [3:0] ext_in = 4'h0;
  logic [11:0] pad_in;
  ppr_pkg::ppr_periph_in_t periph_in_r;
  logic [15:0] route_rd_data_r;
  logic wr_reject_r;
  int err_total = 0, total_checks = 0;
  ppr_pkg::ppr_sel_t codes [17] = '{6'h01, 6'h03, 6'h08, 6'h09, 6'h0a, 6'h0e, 6'h10, 6'h11,
    6'h12, 6'h13, 6'h18, 6'h19, 6'h1a, 6'h32, 6'h2d, 6'h2f, 6'h31};
  int bitpos [17] = '{16, 15, 14, 13, 12, 11, 7, 8, 9, 10, 3, 4, 5, 6, 2, 1, 0};

  always #12.5 ref_clk = ~ref_clk;

  ppr_matrix dut (.ref_clk(ref_clk), .rst_n(rst_n), .cfg_lock(cfg_lock), .wr_key(wr_key),
    .out_wr(out_wr), .out_wr_pin(out_wr_pin), .out_wr_sel(out_wr_sel), .in_wr(in_wr),
    .in_wr_chan(in_wr_chan), .in_wr_sel(in_wr_sel), .route_rd_idx(route_rd_idx),
    .periph_out(periph_out), .port_out(port_out), .port_oe_n(port_oe_n),
    .fixed_out(fixed_out), .fixed_act(fixed_act), .analog_en(analog_en), .pad_in(pad_in),
    .periph_in_r(periph_in_r), .pad_out_r(pad_out_r), .pad_oe_n_r(pad_oe_n_r),
    .route_rd_data_r(route_rd_data_r), .wr_reject_r(wr_reject_r));

  ppr_pad_model pads (.ref_clk(ref_clk), .pad_out_r(pad_out_r), .pad_oe_n_r(pad_oe_n_r),
    .ext_in(ext_in), .pad_in(pad_in));

  // Variant without the CAN and motor blocks; shares every input with dut
  ppr_matrix #(.HAS_CAN(1'b0), .HAS_MOTOR(1'b0)) dut_lite (.ref_clk(ref_clk), .rst_n(rst_n),
    .cfg_lock(cfg_lock), .wr_key(wr_key), .out_wr(out_wr), .out_wr_pin(out_wr_pin),
    .out_wr_sel(out_wr_sel), .in_wr(in_wr), .in_wr_chan(in_wr_chan), .in_wr_sel(in_wr_sel),
    .route_rd_idx(route_rd_idx), .periph_out(periph_out), .port_out(port_out),
    .port_oe_n(port_oe_n), .fixed_out(fixed_out), .fixed_act(fixed_act),
    .analog_en(analog_en), .pad_in(pad_in), .periph_in_r(), .pad_out_r(lite_out),
    .pad_oe_n_r(lite_oe_n), .route_rd_data_r(), .wr_reject_r());

  task automatic finish_test();
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // One strobe cycle; lock and key travel with the strobe
  task automatic wr(input bit is_in, input logic [2:0] idx, input ppr_pkg::ppr_sel_t sel,
      input logic [7:0] key, input logic lock);
    @(posedge ref_clk);
    out_wr <= !is_in;
    in_wr <= is_in;
    out_wr_pin <= idx;
    in_wr_chan <= idx;
    out_wr_sel <= sel;
    in_wr_sel <= sel;
    wr_key <= key;
    cfg_lock <= lock;
    @(posedge ref_clk);
    out_wr <= 1'b0;
    in_wr <= 1'b0;
    cfg_lock <= 1'b0;
  endtask

  initial begin
    #100000;
    err_total++;
    finish_test();
  end

  initial begin
    step(5);
    chk({pad_oe_n_r, route_rd_data_r[7:0]}, 16'hff00);
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    step(1);
    chk({pad_oe_n_r, pad_out_r}, 16'h00ff);
    for (int i = 0; i < 17; i++) begin
      @(posedge ref_clk);
      periph_out <= ppr_pkg::ppr_periph_out_t'(17'h1 << bitpos[i]);
      wr(1'b0, 3'h0, codes[i], 8'h5a, 1'b0);
      step(1);
      chk({pad_oe_n_r[0], pad_out_r[0]}, 2'b01);
      @(posedge ref_clk);
      periph_out <= ppr_pkg::ppr_periph_out_t'(~(17'h1 << bitpos[i]));
      step(1);
      chk({pad_oe_n_r[0], pad_out_r[0]}, 2'b00);
      chk({lite_oe_n[0], lite_out[0]},
        (codes[i] == 6'h0e || codes[i] == 6'h2d || codes[i] == 6'h2f) ? 2'b01 : 2'b00);
    end
    @(posedge ref_clk);
    port_out <= 8'h00;
    port_oe_n <= 8'hff;
    for (int i = 0; i < 2; i++) begin
      wr(1'b0, 3'h0, i ? 6'h3f : 6'h02, 8'h5a, 1'b0);
      step(1);
      chk({pad_oe_n_r[0], pad_out_r[0]}, 2'b10);
    end
    @(posedge ref_clk);
    periph_out <= '0;
    fixed_out <= 8'hff;
    fixed_act <= 8'h01;
    wr(1'b0, 3'h0, 6'h01, 8'h5a, 1'b0);
    step(1);
    chk({pad_oe_n_r[0], pad_out_r[0]}, 2'b00);
    @(posedge ref_clk);
    analog_en <= 8'h01;
    step(1);
    chk({pad_oe_n_r[0], pad_out_r[0]}, 2'b10);
    @(posedge ref_clk);
    analog_en <= 8'h00;
    wr(1'b0, 3'h0, 6'h00, 8'h5a, 1'b0);
    step(1);
    chk({pad_oe_n_r[0], pad_out_r[0]}, 2'b01);
    for (int i = 0; i < 2; i++) begin
      wr(1'b0, 3'h0, 6'h03, i ? 8'h00 : 8'h5a, !i);
      #1;
      chk(wr_reject_r, 1'b1);
      step(1);
      chk(route_rd_data_r, 16'h0000);
    end
    for (int p = 0; p < 8; p++) begin
      wr(1'b0, 3'(p), 6'h01, 8'h5a, 1'b0);
    end
    #1;
    chk(wr_reject_r, 1'b0);
    @(posedge ref_clk);
    periph_out <= ppr_pkg::ppr_periph_out_t'(17'h1 << 16);
    step(1);
    chk({pad_oe_n_r, pad_out_r}, 16'h00ff);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      route_rd_idx <= 2'(i);
      step(1);
      chk(route_rd_data_r, 16'h0101);
    end
    wr(1'b0, 3'h1, 6'h31, 8'h5a, 1'b0);
    @(posedge ref_clk);
    route_rd_idx <= 2'h0;
    step(1);
    chk(route_rd_data_r, 16'h3101);
    wr(1'b1, 3'h4, 6'h01, 8'h5a, 1'b0);
    wr(1'b1, 3'h5, 6'h09, 8'h5a, 1'b0);
    wr(1'b1, 3'h0, 6'h0c, 8'h5a, 1'b0);
    @(posedge ref_clk);
    ext_in <= 4'h9;
    step(1);
    chk(periph_in_r, 6'h31);
    @(posedge ref_clk);
    ext_in <= 4'h0;
    step(1);
    chk(periph_in_r, 6'h10);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    ext_in <= 4'hf;
    step(2);
    chk({pad_oe_n_r, pad_out_r, route_rd_data_r}, 32'hff000000);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    step(1);
    chk({pad_oe_n_r, pad_out_r, route_rd_data_r}, 32'hfe010000);
    chk(periph_in_r, 6'h00);
    finish_test();
  end
endmodule
